//--- hdl/slaw_window_bridge.v
// Address translation windows between the local bus and the serial fabric
`timescale 1ns/10ps
`include "slaw_map.vh"
`default_nettype none

module slaw_window_bridge #(
    parameter OBW          = 2,
    parameter [35:0] BOOT_BASE = 36'h0ff800000,
    parameter [5:0]  BOOT_LOG2 = 6'h17
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // Boot strap pins
    input  wire        boot_loc_pin,
    input  wire        boot_holdoff_pin,
    // Processor start
    output reg         cpu_start_q,
    // Config register space port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [19:0] reg_addr,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata_q,
    output reg         reg_rvalid_q,
    // Maintenance port
    input  wire        maint_wr,
    input  wire        maint_rd,
    input  wire [23:0] maint_offset,
    input  wire [31:0] maint_wdata,
    output reg  [31:0] maint_rdata_q,
    output reg         maint_rvalid_q,
    // Local processor requests
    input  wire        lreq_valid,
    input  wire        lreq_write,
    input  wire [35:0] lreq_addr,
    output reg         lreq_local_q,
    // Outbound fabric requests
    output reg         ob_valid_q,
    output reg         ob_write_q,
    output reg  [3:0]  ob_ttype_q,
    output reg  [9:0]  ob_dest_id_q,
    output reg  [33:0] ob_addr_q,
    output reg  [1:0]  ob_prio_q,
    output reg         ob_pci_order_q,
    // Incoming fabric requests
    input  wire        ireq_valid,
    input  wire        ireq_write,
    input  wire [33:0] ireq_addr,
    input  wire [31:0] ireq_wdata,
    // Inbound to config space
    output reg         ib_cfg_valid_q,
    output reg         ib_cfg_write_q,
    output reg  [19:0] ib_cfg_offset_q,
    output reg  [31:0] ib_cfg_wdata_q,
    // Inbound to local target
    output reg         ib_mem_valid_q,
    output reg         ib_mem_write_q,
    output reg  [3:0]  ib_mem_tgt_q,
    output reg  [3:0]  ib_mem_op_q,
    output reg         ib_mem_snoop_q,
    output reg  [33:0] ib_mem_offset_q,
    output reg  [31:0] ib_mem_wdata_q,
    output reg         ib_reject_q
);

    // ----------------------------------------------------------------
    // Strap synchronisers and capture
    // ----------------------------------------------------------------
    reg  [2:0]  loc_sync_q;
    reg  [2:0]  hold_sync_q;
    reg         loc_filt_q;
    reg         hold_filt_q;
    reg  [1:0]  settle_q;
    reg         straps_done_q;
    reg         boot_loc_q;
    reg         boot_hold_q;
    reg  [31:0] port_ctrl_q;
    reg  [31:0] cfg_base_q;
    reg  [31:0] ibase_q;
    reg  [31:0] iattr_q;

    // Filter's next value; its register lags the agreeing stages by one edge
    wire        loc_next  = (loc_sync_q[1] == loc_sync_q[2]) ? loc_sync_q[2] : loc_filt_q;
    wire        hold_next = (hold_sync_q[1] == hold_sync_q[2]) ? hold_sync_q[2] : hold_filt_q;

    // Straps come from pins, so three stages; a level counts when stages two and three agree
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            loc_sync_q    <= 3'h0;
            hold_sync_q   <= 3'h0;
            loc_filt_q    <= 1'b0;
            hold_filt_q   <= 1'b0;
            settle_q      <= 2'h0;
            straps_done_q <= 1'b0;
            boot_loc_q    <= 1'b0;
            boot_hold_q   <= 1'b0;
        end
        else
        begin
            loc_sync_q  <= {loc_sync_q[1:0], boot_loc_pin};
            hold_sync_q <= {hold_sync_q[1:0], boot_holdoff_pin};
            loc_filt_q  <= loc_next;
            hold_filt_q <= hold_next;
            // Straps are caught once after release and then frozen
            if (!straps_done_q)
            begin
                if (settle_q == `SLAW_STRAP_SETTLE)
                begin
                    straps_done_q <= 1'b1;
                    boot_loc_q    <= loc_next;
                    boot_hold_q   <= hold_next;
                end
                else
                    settle_q <= settle_q + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Processor start control
    // ----------------------------------------------------------------
    // hold-off keeps start low until the port control CPU enable bit is written
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cpu_start_q <= 1'b0;
        else if (straps_done_q && (!boot_hold_q || port_ctrl_q[`SLAW_F_CPU_EN]))
            cpu_start_q <= 1'b1; // Sticky: clearing the enable cannot stop a running core
    end

    // ----------------------------------------------------------------
    // Global registers: port control, config window base, inbound window
    // ----------------------------------------------------------------
    wire maint_cfg_wr = maint_wr && (maint_offset == `SLAW_MAINT_CFG_BASE);

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            port_ctrl_q <= `SLAW_RST_WORD;
            cfg_base_q  <= `SLAW_RST_WORD;
            ibase_q     <= `SLAW_RST_WORD;
            iattr_q     <= `SLAW_RST_WORD;
        end
        else
        begin
            if (reg_wr && reg_addr == `SLAW_OFF_PORT_CTRL)
                port_ctrl_q <= reg_wdata & `SLAW_MASK_PORT_CTRL;
            if (maint_cfg_wr)
                cfg_base_q <= maint_wdata & `SLAW_MASK_CFG_BASE;
            if (reg_wr && reg_addr == `SLAW_OFF_IBW_BASE)
                ibase_q <= reg_wdata & `SLAW_MASK_IBASE;
            if (reg_wr && reg_addr == `SLAW_OFF_IBW_ATTR)
                iattr_q <= reg_wdata & `SLAW_MASK_IATTR;
        end
    end

    // ----------------------------------------------------------------
    // Outbound windows
    // ----------------------------------------------------------------
    // Per-window info: {dest10, prio2, pci1, rdtyp4, wrtyp4, addr34}
    wire [54:0] info_c [0:OBW];
    wire        found_c [0:OBW];
    wire [31:0] rd_c [0:OBW];
    wire [54:0] win0_info;

    assign info_c[0]  = 55'h0;
    assign found_c[0] = 1'b0;
    assign rd_c[0]    = 32'h0;

    genvar g;
    generate
        for (g = 0; g < OBW; g = g + 1)
        begin : g_obw
            localparam [19:0] WB    = `SLAW_OFF_OBW_BLOCK + (g << `SLAW_OBW_STRIDE_LOG2);
            localparam [31:0] AMASK = (g == 0) ? (`SLAW_MASK_OATTR & 32'h7fffffff)
                                               : `SLAW_MASK_OATTR;
            localparam [31:0] ARST  = (g == 0) ? `SLAW_RST_OATTR0 : `SLAW_RST_WORD;
            reg  [31:0] trans_q;
            reg  [31:0] base_q;
            reg  [31:0] attr_q;
            wire        sel_t = (reg_addr == (WB | `SLAW_OFF_OBW_TRANS));
            wire        sel_b = (reg_addr == (WB | `SLAW_OFF_OBW_BASE));
            wire        sel_a = (reg_addr == (WB | `SLAW_OFF_OBW_ATTR));
            wire [35:0] base36;
            wire [36:0] span;
            wire [36:0] lim;
            wire [35:0] off36;
            wire [33:0] xaddr;
            wire        hit;
            wire [54:0] info;

            always @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                begin
                    trans_q <= `SLAW_RST_WORD;
                    base_q  <= `SLAW_RST_WORD;
                    attr_q  <= ARST;
                end
                else
                begin
                    if (reg_wr && sel_t)
                        trans_q <= reg_wdata & `SLAW_MASK_OTRANS;
                    if (reg_wr && sel_b)
                        base_q <= reg_wdata & `SLAW_MASK_OBASE;
                    if (reg_wr && sel_a)
                        attr_q <= (attr_q & ~AMASK) | (reg_wdata & AMASK);
                end
            end

            // base from extended and start bits
            assign base36 = {base_q[`SLAW_F_EXT4], base_q[`SLAW_F_ADDR], 12'h000};
            // span of two power n+1 bytes
            assign span   = (attr_q[`SLAW_F_SIZE] >= 6'h23) ? 37'h1000000000
                          : (37'h1 << (attr_q[`SLAW_F_SIZE] + 6'h1));
            assign lim    = {1'b0, base36} + span;
            assign hit    = attr_q[`SLAW_F_EN] && (lreq_addr >= base36)
                          && ({1'b0, lreq_addr} < lim);
            assign off36  = lreq_addr - base36;
            assign xaddr  = {trans_q[`SLAW_F_EXT2], trans_q[`SLAW_F_ADDR], 12'h000}
                          + off36[33:0];
            // large ID bits sit above the small ID
            // segment fields do not split the window
            assign info   = {trans_q[`SLAW_F_LTGT], trans_q[`SLAW_F_TGT],
                             attr_q[`SLAW_F_PRIO], attr_q[`SLAW_F_PCI],
                             attr_q[`SLAW_F_READ_REQUEST_TYPE], attr_q[`SLAW_F_WRITE_REQUEST_TYPE], xaddr};
            // Lowest numbered hitting window wins
            assign info_c[g+1]  = (!found_c[g] && hit) ? info : info_c[g];
            assign found_c[g+1] = found_c[g] | hit;
            assign rd_c[g+1]    = rd_c[g] | (sel_t ? trans_q : 32'h0)
                                | (sel_b ? base_q : 32'h0) | (sel_a ? attr_q : 32'h0);
            if (g == 0)
            begin : g_win0
                assign win0_info = info;
            end
        end
    endgenerate

    // boot region forced through window zero
    wire [35:0] boot_top  = BOOT_BASE + (36'h1 << BOOT_LOG2);
    wire        boot_hit  = boot_loc_q && (lreq_addr >= BOOT_BASE) && (lreq_addr < boot_top);
    wire [54:0] sel_info  = boot_hit ? win0_info : info_c[OBW];
    wire        ob_hit    = boot_hit | found_c[OBW];

    // Outbound request register
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ob_valid_q     <= 1'b0;
            ob_write_q     <= 1'b0;
            ob_ttype_q     <= 4'h0;
            ob_dest_id_q   <= 10'h000;
            ob_addr_q      <= 34'h0;
            ob_prio_q      <= 2'h0;
            ob_pci_order_q <= 1'b0;
            lreq_local_q   <= 1'b0;
        end
        else
        begin
            ob_valid_q   <= lreq_valid && ob_hit;
            lreq_local_q <= lreq_valid && !ob_hit;
            if (lreq_valid && ob_hit)
            begin
                ob_write_q     <= lreq_write;
                ob_ttype_q     <= lreq_write ? sel_info[37:34] : sel_info[41:38];
                ob_dest_id_q   <= sel_info[54:45];
                ob_prio_q      <= sel_info[44:43];
                ob_pci_order_q <= sel_info[42];
                ob_addr_q      <= sel_info[33:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Inbound decode
    // ----------------------------------------------------------------
    wire [33:0] ibase34 = {ibase_q[`SLAW_F_EXT2], ibase_q[`SLAW_F_ADDR], 12'h000};
    // inbound span of two power n+1 bytes
    wire [34:0] ispan   = (iattr_q[`SLAW_F_SIZE] >= 6'h21) ? 35'h400000000
                        : (35'h1 << (iattr_q[`SLAW_F_SIZE] + 6'h1));
    wire [34:0] ilim    = {1'b0, ibase34} + ispan;
    wire        cfg_hit = (ireq_addr[33:20] == cfg_base_q[`SLAW_F_CFG_BASE]);
    wire        ib_hit  = iattr_q[`SLAW_F_EN] && (ireq_addr >= ibase34)
                        && ({1'b0, ireq_addr} < ilim);
    wire        ib_ro   = (iattr_q[`SLAW_F_WRITE_REQUEST_TYPE] == `SLAW_IB_WR_RESERVED);
    wire        ib_ok   = ib_hit && !cfg_hit && !(ireq_write && ib_ro);
    wire [33:0] ioff    = ireq_addr - ibase34;

    // Inbound routing register; the config window has priority over the memory window
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ib_cfg_valid_q  <= 1'b0;
            ib_cfg_write_q  <= 1'b0;
            ib_cfg_offset_q <= 20'h00000;
            ib_cfg_wdata_q  <= 32'h0;
            ib_mem_valid_q  <= 1'b0;
            ib_mem_write_q  <= 1'b0;
            ib_mem_tgt_q    <= 4'h0;
            ib_mem_op_q     <= 4'h0;
            ib_mem_snoop_q  <= 1'b0;
            ib_mem_offset_q <= 34'h0;
            ib_mem_wdata_q  <= 32'h0;
            ib_reject_q     <= 1'b0;
        end
        else
        begin
            ib_cfg_valid_q <= ireq_valid && cfg_hit;
            ib_mem_valid_q <= ireq_valid && ib_ok;
            ib_reject_q    <= ireq_valid && !cfg_hit && !ib_ok;
            if (ireq_valid && cfg_hit)
            begin
                ib_cfg_write_q  <= ireq_write;
                ib_cfg_offset_q <= ireq_addr[19:0];
                ib_cfg_wdata_q  <= ireq_wdata;
            end
            if (ireq_valid && ib_ok)
            begin
                ib_mem_write_q  <= ireq_write;
                ib_mem_tgt_q    <= iattr_q[`SLAW_F_IBTGT];
                ib_mem_op_q     <= ireq_write ? iattr_q[`SLAW_F_WRITE_REQUEST_TYPE] : iattr_q[`SLAW_F_READ_REQUEST_TYPE];
                ib_mem_snoop_q  <= !ireq_write
                                && (iattr_q[`SLAW_F_READ_REQUEST_TYPE] == `SLAW_IB_RD_SNOOP);
                ib_mem_offset_q <= ioff;
                ib_mem_wdata_q  <= ireq_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register and maintenance read-back
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;

    // Unmapped offsets read as zero
    always @*
    begin
        rd_mux = rd_c[OBW];
        case (reg_addr)
            `SLAW_OFF_PORT_CTRL: rd_mux = port_ctrl_q;
            `SLAW_OFF_STATUS:    rd_mux = {28'h0, straps_done_q, boot_loc_q,
                                           boot_hold_q, cpu_start_q};
            `SLAW_OFF_CFG_BASE:  rd_mux = cfg_base_q;
            `SLAW_OFF_IBW_BASE:  rd_mux = ibase_q;
            `SLAW_OFF_IBW_ATTR:  rd_mux = iattr_q;
            default:             rd_mux = rd_c[OBW];
        endcase
    end

    // One cycle read latency on both ports
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata_q    <= 32'h0;
            reg_rvalid_q   <= 1'b0;
            maint_rdata_q  <= 32'h0;
            maint_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q   <= reg_rd;
            maint_rvalid_q <= maint_rd;
            if (reg_rd)
                reg_rdata_q <= rd_mux;
            if (maint_rd)
                maint_rdata_q <= (maint_offset == `SLAW_MAINT_CFG_BASE) ? cfg_base_q : 32'h0;
        end
    end

endmodule

`default_nettype wire

//--- hdl/slaw_map.vh
// Register offsets, field positions, codes and reset values of the window bridge
`ifndef SLAW_MAP_VH
`define SLAW_MAP_VH

// ----------------------------------------------------------------
// Offsets: maintenance space and local configuration space
// ----------------------------------------------------------------
`define SLAW_MAINT_CFG_BASE   24'h00005c
`define SLAW_OFF_PORT_CTRL    20'h00000
`define SLAW_OFF_STATUS       20'h00004
`define SLAW_OFF_CFG_BASE     20'h0005c
`define SLAW_OFF_OBW_BLOCK    20'h00100
`define SLAW_OBW_STRIDE_LOG2  5
`define SLAW_OFF_OBW_TRANS    20'h00000
`define SLAW_OFF_OBW_BASE     20'h00008
`define SLAW_OFF_OBW_ATTR     20'h00010
`define SLAW_OFF_IBW_BASE     20'h00208
`define SLAW_OFF_IBW_ATTR     20'h00210

// ----------------------------------------------------------------
// Field positions (bit 31 is the first bit of each word)
// ----------------------------------------------------------------
`define SLAW_F_EN        31
`define SLAW_F_EXT4      23:20
`define SLAW_F_EXT2      21:20
`define SLAW_F_ADDR      19:0
`define SLAW_F_PRIO      27:26
`define SLAW_F_PCI       25
`define SLAW_F_SEGMENT_COUNT      23:22
`define SLAW_F_SUBSEGMENT_COUNT     21:20
`define SLAW_F_READ_REQUEST_TYPE     19:16
`define SLAW_F_WRITE_REQUEST_TYPE     15:12
`define SLAW_F_SIZE      5:0
`define SLAW_F_LTGT      31:30
`define SLAW_F_TGT       29:22
`define SLAW_F_IBTGT     23:20
`define SLAW_F_CFG_BASE  30:17
`define SLAW_F_CPU_EN    31

// ----------------------------------------------------------------
// Codes, writable masks and reset values
// ----------------------------------------------------------------
`define SLAW_TT_NREAD        4'h4
`define SLAW_TT_NWRITE_R     4'h5
`define SLAW_IB_TGT_MEM      4'hf
`define SLAW_IB_RD_SNOOP     4'h5
`define SLAW_IB_WR_RESERVED  4'h0
`define SLAW_SIZE_1MB        6'h13
`define SLAW_SIZE_16MB       6'h17
`define SLAW_MASK_OBASE      32'h00ffffff
`define SLAW_MASK_OATTR      32'h8efff03f
`define SLAW_MASK_OTRANS     32'hffffffff
`define SLAW_MASK_IBASE      32'h003fffff
`define SLAW_MASK_IATTR      32'h80fff03f
`define SLAW_MASK_CFG_BASE   32'h7ffe0000
`define SLAW_MASK_PORT_CTRL  32'h80000000
`define SLAW_RST_WORD        32'h00000000
`define SLAW_RST_OATTR0      32'h80000000
`define SLAW_STRAP_SETTLE    2'h3

`endif

//--- dv/slaw_fabric_host.sv
// Fabric host model: incoming requests and maintenance accesses
`timescale 1ns/10ps
`default_nettype none
module slaw_fabric_host (
    // Clock
    input  wire         clk_sys,
    // Incoming requests
    output logic        ireq_valid,
    output logic        ireq_write,
    output logic [33:0] ireq_addr,
    output logic [31:0] ireq_wdata,
    // Maintenance requests
    output logic        maint_wr,
    output logic        maint_rd,
    output logic [23:0] maint_offset,
    output logic [31:0] maint_wdata
);
    // Idle at time zero
    initial
    begin
        {ireq_valid, ireq_write, ireq_addr, ireq_wdata} = '0;
        {maint_wr, maint_rd, maint_offset, maint_wdata} = '0;
    end
    task automatic send(input logic w, input logic [33:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        ireq_valid <= 1'b1;
        ireq_write <= w;
        ireq_addr  <= a;
        ireq_wdata <= d;
        @(posedge clk_sys);
        ireq_valid <= 1'b0;
        // Released lines flip so a stale value never looks current
        ireq_addr  <= ~a;
        ireq_wdata <= ~d;
    endtask
    task automatic maint(input logic w, input logic [23:0] o, input logic [31:0] d);
        @(posedge clk_sys);
        maint_wr     <= w;
        maint_rd     <= !w;
        maint_offset <= o;
        maint_wdata  <= d;
        @(posedge clk_sys);
        maint_wr     <= 1'b0;
        maint_rd     <= 1'b0;
        maint_offset <= ~o;
        maint_wdata  <= ~d;
    endtask
endmodule
`default_nettype wire

//--- dv/slaw_window_bridge_sva.sv
// Port-level assertions of the window bridge
`timescale 1ns/10ps
`default_nettype none
module slaw_window_bridge_sva (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // Request side
    input  wire        reg_rd,
    input  wire        maint_rd,
    input  wire        lreq_valid,
    input  wire        ireq_valid,
    input  wire        ireq_write,
    input  wire [33:0] ireq_addr,
    // Answer side
    input  wire        reg_rvalid_q,
    input  wire        maint_rvalid_q,
    input  wire        cpu_start_q,
    input  wire        lreq_local_q,
    input  wire        ob_valid_q,
    input  wire        ib_cfg_valid_q,
    input  wire        ib_cfg_write_q,
    input  wire [19:0] ib_cfg_offset_q,
    input  wire        ib_mem_valid_q,
    input  wire        ib_mem_write_q,
    input  wire        ib_mem_snoop_q,
    input  wire        ib_reject_q
);
    // ----------------------------------------
    // Single domain, so one clock and disable
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    property p_lreq_ans; lreq_valid |=> ob_valid_q != lreq_local_q; endproperty
    a_lreq_ans: assert property (p_lreq_ans) else $error("local request answer wrong");
    property p_lreq_idle; !lreq_valid |=> !ob_valid_q && !lreq_local_q; endproperty
    a_lreq_idle: assert property (p_lreq_idle) else $error("spurious local answer");
    property p_ib_one; ireq_valid |=> $onehot({ib_cfg_valid_q, ib_mem_valid_q, ib_reject_q});
    endproperty
    a_ib_one: assert property (p_ib_one) else $error("inbound route not unique");
    property p_ib_idle; !ireq_valid |=> !(ib_cfg_valid_q || ib_mem_valid_q || ib_reject_q);
    endproperty
    a_ib_idle: assert property (p_ib_idle) else $error("spurious inbound answer");
    property p_cfg_off; ireq_valid ##1 ib_cfg_valid_q |-> ib_cfg_offset_q == $past(ireq_addr[19:0]);
    endproperty
    a_cfg_off: assert property (p_cfg_off) else $error("config offset wrong");
    property p_cfg_wr; ireq_valid ##1 ib_cfg_valid_q |-> ib_cfg_write_q == $past(ireq_write);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config direction wrong");
    property p_reg_rv; reg_rd |=> reg_rvalid_q; endproperty
    a_reg_rv: assert property (p_reg_rv) else $error("register read not answered");
    property p_maint_rv; maint_rd |=> maint_rvalid_q; endproperty
    a_maint_rv: assert property (p_maint_rv) else $error("maintenance read not answered");
    property p_cpu_hold; cpu_start_q |=> cpu_start_q; endproperty
    a_cpu_hold: assert property (p_cpu_hold) else $error("processor start dropped");
    property p_snoop; ib_mem_valid_q && ib_mem_snoop_q |-> !ib_mem_write_q; endproperty
    a_snoop: assert property (p_snoop) else $error("snoop flagged on a write");
endmodule
bind slaw_window_bridge slaw_window_bridge_sva chk_u (.clk_sys(clk_sys), .rstn(rstn),
    .reg_rd(reg_rd), .maint_rd(maint_rd), .lreq_valid(lreq_valid), .ireq_valid(ireq_valid),
    .ireq_write(ireq_write), .ireq_addr(ireq_addr), .reg_rvalid_q(reg_rvalid_q),
    .maint_rvalid_q(maint_rvalid_q), .cpu_start_q(cpu_start_q), .lreq_local_q(lreq_local_q),
    .ob_valid_q(ob_valid_q), .ib_cfg_valid_q(ib_cfg_valid_q), .ib_cfg_write_q(ib_cfg_write_q),
    .ib_cfg_offset_q(ib_cfg_offset_q), .ib_mem_valid_q(ib_mem_valid_q),
    .ib_mem_write_q(ib_mem_write_q), .ib_mem_snoop_q(ib_mem_snoop_q), .ib_reject_q(ib_reject_q));
`default_nettype wire

//--- dv/slaw_window_bridge_tb.sv
// Self-checking bench of the window bridge
`timescale 1ns/10ps
`default_nettype none
module slaw_window_bridge_tb;
    logic        clk_sys, rstn, boot_loc_pin, boot_holdoff_pin, tb_wr, tb_rd;
    logic        lreq_valid, lreq_write;
    logic [19:0] tb_addr;
    logic [31:0] tb_wdata;
    logic [35:0] lreq_addr;
    int          failures, n_compared, cyc;
    wire         reg_wr, reg_rd, maint_wr, maint_rd, ireq_valid, ireq_write, cpu_start_q;
    wire         reg_rvalid_q, maint_rvalid_q, lreq_local_q, ob_valid_q, ob_write_q;
    wire         ob_pci_order_q, ib_cfg_valid_q, ib_cfg_write_q, ib_mem_valid_q;
    wire         ib_mem_write_q, ib_mem_snoop_q, ib_reject_q;
    wire [1:0]   ob_prio_q;
    wire [3:0]   ob_ttype_q, ib_mem_tgt_q, ib_mem_op_q;
    wire [9:0]   ob_dest_id_q;
    wire [19:0]  reg_addr, ib_cfg_offset_q;
    wire [23:0]  maint_offset;
    wire [31:0]  reg_wdata, reg_rdata_q, maint_wdata, maint_rdata_q, ireq_wdata;
    wire [31:0]  ib_cfg_wdata_q, ib_mem_wdata_q;
    wire [33:0]  ireq_addr, ob_addr_q, ib_mem_offset_q;
    // Config window hits loop back onto the register port
    assign reg_wr    = tb_wr | (ib_cfg_valid_q & ib_cfg_write_q);
    assign reg_rd    = tb_rd | (ib_cfg_valid_q & !ib_cfg_write_q);
    assign reg_addr  = ib_cfg_valid_q ? ib_cfg_offset_q : tb_addr;
    assign reg_wdata = ib_cfg_valid_q ? ib_cfg_wdata_q : tb_wdata;
    slaw_window_bridge dut_u (.*);
    slaw_fabric_host fab_u (.*);
    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Hang guard, far above the hundred or fewer cycles used
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rw(input logic w, input logic [19:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        tb_wr    <= w;
        tb_rd    <= !w;
        tb_addr  <= a;
        tb_wdata <= d;
        @(posedge clk_sys);
        tb_wr    <= 1'b0;
        tb_rd    <= 1'b0;
        #1;
        if (!w) chk("rdata", {4'h1, d}, {3'h0, reg_rvalid_q, reg_rdata_q});
    endtask
    task automatic lreq(input logic w, input logic [35:0] a);
        @(posedge clk_sys);
        lreq_valid <= 1'b1;
        lreq_write <= w;
        lreq_addr  <= a;
        @(posedge clk_sys);
        lreq_valid <= 1'b0;
        lreq_addr  <= ~a;
        #1;
    endtask
    task automatic ib(input logic w, input logic [33:0] a, input logic [2:0] route);
        fab_u.send(w, a, 32'h80000000);
        #1;
        chk("ib_route", route, {ib_cfg_valid_q, ib_mem_valid_q, ib_reject_q});
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        repeat (8) @(posedge clk_sys);
        rw(0, 20'h00004, 32'h0000000e);
        rw(0, 20'h00110, 32'h80000000);
        rw(1, 20'h00110, 32'h00000000);
        rw(0, 20'h00110, 32'h80000000);
        rw(1, 20'h00128, 32'hffffffff);
        rw(0, 20'h00128, 32'h00ffffff);
        rw(1, 20'h00130, 32'hffffffff);
        rw(0, 20'h00130, 32'h8efff03f);
        rw(1, 20'h000f0, 32'hffffffff);
        rw(0, 20'h000f0, 32'h00000000);
        $display("t_regs done");
    endtask
    task automatic t_outbound();
        rw(1, 20'h00128, 32'h000c1100);
        rw(1, 20'h00130, 32'h80045013);
        rw(1, 20'h00120, 32'h00401000);
        lreq(0, 36'h0c11c005c);
        chk("ob_read", {2'h2, 4'h4, 10'h001, 2'h0, 1'b0},
            {ob_valid_q, ob_write_q, ob_ttype_q, ob_dest_id_q, ob_prio_q, ob_pci_order_q});
        chk("ob_addr", 36'h0010c005c, {2'h0, ob_addr_q});
        rw(1, 20'h00130, 32'h8a045013);
        rw(1, 20'h00120, 32'h80401000);
        lreq(1, 36'h0c1100000);
        chk("ob_write", {2'h3, 4'h5, 10'h201, 2'h2, 1'b1},
            {ob_valid_q, ob_write_q, ob_ttype_q, ob_dest_id_q, ob_prio_q, ob_pci_order_q});
        chk("ob_addr", 36'h001000000, {2'h0, ob_addr_q});
        lreq(0, 36'h0c1200000);
        chk("ob_miss", 2'h1, {ob_valid_q, lreq_local_q});
        $display("t_outbound done");
    endtask
    task automatic t_inbound();
        fab_u.maint(1, 24'h00005c, 32'h00200000);
        fab_u.maint(0, 24'h00005c, 32'h0);
        #1;
        chk("maint_rd", 33'h100200000, {maint_rvalid_q, maint_rdata_q});
        ib(0, 34'h00100005c, 3'b100);
        ib(0, 34'h001100000, 3'b001);
        rw(1, 20'h00208, 32'h00000200);
        rw(1, 20'h00210, 32'h80f50017);
        ib(0, 34'h000200040, 3'b010);
        chk("ib_mem", {4'hf, 4'h5, 1'b1}, {ib_mem_tgt_q, ib_mem_op_q, ib_mem_snoop_q});
        chk("ib_off", 36'h40, {2'h0, ib_mem_offset_q});
        ib(0, 34'h0011fffff, 3'b010);
        chk("ib_off", 36'hffffff, {2'h0, ib_mem_offset_q});
        ib(0, 34'h001200000, 3'b001);
        ib(1, 34'h000200040, 3'b001);
        $display("t_inbound done");
    endtask
    task automatic t_boot();
        rw(1, 20'h00100, 32'h00002000);
        rw(1, 20'h00108, 32'h000ff000);
        rw(1, 20'h00110, 32'h80045000);
        lreq(0, 36'h0ff800000);
        chk("boot_fetch", 1'b1, ob_valid_q);
        chk("boot_addr", 36'h002800000, {2'h0, ob_addr_q});
        chk("held", 1'b0, cpu_start_q);
        ib(1, 34'h001000000, 3'b100);
        repeat (4) @(posedge clk_sys);
        chk("started", 1'b1, cpu_start_q);
        $display("t_boot done");
    endtask
    initial
    begin
        {rstn, tb_wr, tb_rd, tb_addr, tb_wdata, lreq_valid, lreq_write, lreq_addr} = '0;
        {failures, n_compared, cyc} = '0;
        boot_loc_pin     = 1'b1;
        boot_holdoff_pin = 1'b1;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs();
        t_outbound();
        t_inbound();
        t_boot();
        wrap_up();
    end
endmodule
`default_nettype wire
